/* verilog/frag_regs.svh */
/*
 * Register offsets, field layouts, reset values and timing counts of the
 * flash region access guard. Assumes a 32-bit register port with word
 * addressing in bytes and a flash of FRAG_FLASH_BYTES bytes.
 */
`ifndef FRAG_REGS_SVH
`define FRAG_REGS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define FRAG_NUM_REGIONS 4
`define FRAG_ADDR_W 20
`define FRAG_PERMISSION_REG_W 2
`define FRAG_FLASH_BYTES 21'h100000
`define FRAG_PAGE_BITS 12
`define FRAG_ZERO_ADDR 20'h00000
`define FRAG_ZERO_PERMISSION_REG 2'h0

// ****************************************************************
// Register map: region n at base + n * stride
// ****************************************************************
`define FRAG_REG_BASE 8'h00
`define FRAG_REG_STRIDE 8'h10
`define FRAG_OFS_START 4'h0
`define FRAG_OFS_LENGTH 4'h4
`define FRAG_OFS_PERMISSION_REG 4'h8
`define FRAG_OFS_STATUS 4'hc

// ****************************************************************
// Permission bits: a set bit forbids the access
// ****************************************************************
`define FRAG_PERMISSION_REG_NO_WRITE 1
`define FRAG_PERMISSION_REG_NO_READ 2

// ****************************************************************
// Timing
// ****************************************************************
`define FRAG_ARM_DELAY 2'h2

`endif

/* verilog/frag_pkg.sv */
/*
 * Types of the flash region access guard.
 * Assumes frag_regs.svh is compiled before this package.
 */
`include "frag_regs.svh"

package frag_pkg;

    // Configuration of one region and its write-once marks
    typedef struct packed {
        logic [`FRAG_ADDR_W-1:0] start;
        logic [`FRAG_ADDR_W:0] length;
        logic [`FRAG_PERMISSION_REG_W-1:0] permission_reg;
        logic start_wr;
        logic length_wr;
        logic permission_reg_wr;
        logic [1:0] arm_cnt;
        logic enforced;
    } frag_region_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } frag_reg_req_s;

    // One flash access from a bus master
    typedef struct packed {
        logic valid;
        logic write;
        logic debug;
        logic [`FRAG_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } frag_acc_s;

    typedef enum logic [1:0] {
        FRAG_ST_IDLE = 2'h1,
        FRAG_ST_READ = 2'h2
    } frag_rd_state_e;

endpackage : frag_pkg

/* verilog/frag_guard.sv */
/*
 * Flash region access guard: write-once region registers and the access
 * filter between the bus masters and the flash array.
 * Assumes flash reads return data in the cycle of the forwarded request and that the
 * register port and the master port are synchronous to clk.
 */
`timescale 1ns/10ps
`include "frag_regs.svh"

// Overview of operation
// - A region is enforced two clock cycles after all three registers are written.
// - Enforce only with page-aligned valid start and nonzero length and permission.
// - Each start, length and permission register takes only the first write.
// - Only reset clears the configuration registers.
// - Debugger reads inside a read-protected region return zero.
// - Debugger writes inside a write-protected region are dropped.
module frag_guard (
    input wire logic clk,
    input wire logic reset_n,
    input wire frag_pkg::frag_reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    input wire frag_pkg::frag_acc_s acc,
    output frag_pkg::frag_acc_s flash_acc,
    input wire logic [31:0] flash_rdata,
    output logic [31:0] acc_rdata,
    output logic acc_denied
);

    // ****************************************************************
    // State
    // ****************************************************************
    // Everything the guard remembers but acc_rdata sits in one record, registered in
    // one place, so a reset cannot miss a field
    typedef struct packed {
        frag_pkg::frag_region_s [`FRAG_NUM_REGIONS-1:0] rgn;
        logic [31:0] rdata;
        frag_pkg::frag_acc_s flash;
        logic rd_zero;
        logic denied;
        frag_pkg::frag_rd_state_e rd_st;
    } frag_state_s;

    // Present and next copy of the record
    frag_state_s st_r;
    frag_state_s st_nxt;
    logic [31:0] out_rdata;

    // Region index and register offset of a port address
    // Indices above the last region match nothing and read as zero
    function automatic logic [3:0] reg_ofs(input logic [7:0] a);
        reg_ofs = a[3:0];
    endfunction : reg_ofs

    function automatic logic [3:0] reg_idx(input logic [7:0] a);
        reg_idx = a[7:4];
    endfunction : reg_idx

    // Does an enforced region cover this address
    // One bit wider than the address, so the end of the top page cannot wrap
    function automatic logic covers(input frag_pkg::frag_region_s r, input logic [`FRAG_ADDR_W-1:0] a);
        logic [`FRAG_ADDR_W:0] ofs;
        ofs = {1'b0, a} - {1'b0, r.start};
        covers = r.enforced && (a >= r.start) && (ofs < r.length);
    endfunction : covers

    // Validity of the written triple; the length ceiling is on software
    // A misaligned start leaves the region idle rather than rounding it
    function automatic logic triple_ok(input frag_pkg::frag_region_s r);
        triple_ok = r.start_wr && r.length_wr && r.permission_reg_wr
            && (r.start[`FRAG_PAGE_BITS-1:0] == '0)
            && (r.length != '0) && (r.permission_reg != `FRAG_ZERO_PERMISSION_REG);
    endfunction : triple_ok

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic no_rd;
        logic no_wr;
        logic hit;
        st_nxt = st_r;
        no_rd = 1'b0;
        no_wr = 1'b0;
        hit = 1'b0;
        // Read data stand for one cycle only, then fall back to zero
        st_nxt.rdata = '0;
        // Region registers; writes after the first are ignored, not errored
        // Software sees no error, so boot code must read status back
        for (int i = 0; i < `FRAG_NUM_REGIONS; i++) begin
            if (reg_req.wr && reg_idx(reg_req.addr) == 4'(i)) begin
                unique case (reg_ofs(reg_req.addr))
                    `FRAG_OFS_START: if (!st_r.rgn[i].start_wr) begin
                        st_nxt.rgn[i].start = reg_req.wdata[`FRAG_ADDR_W-1:0];
                        st_nxt.rgn[i].start_wr = 1'b1;
                    end
                    `FRAG_OFS_LENGTH: if (!st_r.rgn[i].length_wr) begin
                        st_nxt.rgn[i].length = reg_req.wdata[`FRAG_ADDR_W:0];
                        st_nxt.rgn[i].length_wr = 1'b1;
                    end
                    `FRAG_OFS_PERMISSION_REG: if (!st_r.rgn[i].permission_reg_wr) begin
                        st_nxt.rgn[i].permission_reg = reg_req.wdata[`FRAG_PERMISSION_REG_W-1:0];
                        st_nxt.rgn[i].permission_reg_wr = 1'b1;
                    end
                    default: ;
                endcase
            end
            // Arming countdown; bad triples never arm
            // The count stops once enforced, so the flag never drops before reset
            if (triple_ok(st_r.rgn[i]) && !st_r.rgn[i].enforced) begin
                if (st_r.rgn[i].arm_cnt == `FRAG_ARM_DELAY - 2'h1)
                    st_nxt.rgn[i].enforced = 1'b1;
                else
                    st_nxt.rgn[i].arm_cnt = st_r.rgn[i].arm_cnt + 2'h1;
            end
            // Read-back of the stored fields and of the status word
            if (reg_req.rd && reg_idx(reg_req.addr) == 4'(i)) begin
                unique case (reg_ofs(reg_req.addr))
                    `FRAG_OFS_START: st_nxt.rdata = 32'(st_r.rgn[i].start);
                    `FRAG_OFS_LENGTH: st_nxt.rdata = 32'(st_r.rgn[i].length);
                    `FRAG_OFS_PERMISSION_REG: st_nxt.rdata = 32'(st_r.rgn[i].permission_reg);
                    `FRAG_OFS_STATUS: st_nxt.rdata = {28'h0, st_r.rgn[i].enforced,
                        st_r.rgn[i].permission_reg_wr, st_r.rgn[i].length_wr, st_r.rgn[i].start_wr};
                    default: st_nxt.rdata = '0;
                endcase
            end
            // Union of all covering regions' restrictions
            // A bit set by any covering region forbids the access
            if (covers(st_r.rgn[i], acc.addr)) begin
                hit = 1'b1;
                no_rd = no_rd | st_r.rgn[i].permission_reg[`FRAG_PERMISSION_REG_NO_READ-1];
                no_wr = no_wr | st_r.rgn[i].permission_reg[`FRAG_PERMISSION_REG_NO_WRITE-1];
            end
        end
        // Filter: same treatment for debugger and other masters
        // The master kind is passed on but never tested: no master gains
        // what a debugger is refused, and the filter stays one level deep
        st_nxt.flash = acc;
        st_nxt.denied = 1'b0;
        st_nxt.rd_zero = 1'b0;
        st_nxt.rd_st = frag_pkg::FRAG_ST_IDLE;
        if (acc.valid && acc.write && hit && no_wr) begin
            st_nxt.flash.valid = 1'b0;
            st_nxt.denied = 1'b1;
        end
        if (acc.valid && !acc.write) begin
            st_nxt.rd_st = frag_pkg::FRAG_ST_READ;
            if (hit && no_rd) begin
                st_nxt.flash.valid = 1'b0;
                st_nxt.rd_zero = 1'b1;
                st_nxt.denied = 1'b1;
            end
        end
    end

    // Registered outputs; reset is the only clear path
    // The reset branch loads constants only; no other path clears a region
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.rd_st <= frag_pkg::FRAG_ST_IDLE;
            acc_rdata <= '0;
        end else begin
            st_r <= st_nxt;
            acc_rdata <= out_rdata;
        end
    end

    // Read data of a read accepted last cycle; zero where it was refused
    // Flash data are taken in the cycle of the forwarded read, as the array answers at once
    always_comb begin
        out_rdata = '0;
        if (st_r.rd_st == frag_pkg::FRAG_ST_READ && !st_r.rd_zero)
            out_rdata = flash_rdata;
    end

    // Every output but acc_rdata is a field of the registered record
    assign reg_rdata = st_r.rdata;
    assign flash_acc = st_r.flash;
    assign acc_denied = st_r.denied;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // A write that the filter refuses must not reach the array
    a_write_dropped: assert property (@(posedge clk) disable iff (!reset_n)
        (acc.valid && acc.write && st_nxt.denied) |=> !flash_acc.valid)
        else $error("Forbidden write reached flash");

    // A refused read answers zero one cycle after the refusal
    a_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.rd_zero) |=> (acc_rdata == '0))
        else $error("Forbidden read returned data");

    // Region 0 keeps the start it took first
    a_once_start: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.rgn[0].start_wr) |=> $stable(st_r.rgn[0].start))
        else $error("Start register changed after first write");

    // Region 0 arms exactly two cycles after its triple becomes valid
    a_arm_delay: assert property (@(posedge clk) disable iff (!reset_n)
        ($rose(triple_ok(st_r.rgn[0])) && !st_r.rgn[0].enforced) |-> !st_r.rgn[0].enforced ##2 st_r.rgn[0].enforced)
        else $error("Region not enforced two cycles after setup");

    // An enforced region 0 never has an empty length or permission
    a_bad_triple: assert property (@(posedge clk) disable iff (!reset_n)
        st_r.rgn[0].enforced |-> (st_r.rgn[0].permission_reg != '0 && st_r.rgn[0].length != '0))
        else $error("Invalid region enforced");

    // Only reset takes enforcement away
    a_no_clear: assert property (@(posedge clk) disable iff (!reset_n)
        $past(st_r.rgn[0].enforced) |-> st_r.rgn[0].enforced)
        else $error("Enforcement cleared without reset");

    // A read forbidden by region 0 is refused whatever other regions allow
    a_union_rd: assert property (@(posedge clk) disable iff (!reset_n)
        (acc.valid && !acc.write && covers(st_r.rgn[0], acc.addr) && st_r.rgn[0].permission_reg[1]) |=> acc_denied)
        else $error("Overlap did not combine restrictions");

    // Processor writes get the debugger's treatment
    a_cpu_write: assert property (@(posedge clk) disable iff (!reset_n)
        (acc.valid && acc.write && !acc.debug && covers(st_r.rgn[0], acc.addr) && st_r.rgn[0].permission_reg[0])
        |=> (acc_denied && !flash_acc.valid))
        else $error("Forbidden processor write not dropped");

    // A zeroed read is never forwarded to the array
    a_zero_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        st_r.rd_zero |-> !flash_acc.valid)
        else $error("Refused read was forwarded to flash");

    // A refused write is never forwarded to the array
    a_drop_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        (acc_denied && flash_acc.write) |-> !flash_acc.valid)
        else $error("Refused write was forwarded to flash");

    // ****************************************************************
    // Per-region checks
    // ****************************************************************
    // One copy per region, so a fault in regions 1 to 3 cannot hide
    // behind a sound region 0
    for (genvar g = 0; g < `FRAG_NUM_REGIONS; g++) begin : g_rgn_chk
        // A written start never moves again until reset
        a_keep_start: assert property (@(posedge clk) disable iff (!reset_n)
            st_r.rgn[g].start_wr |=> $stable(st_r.rgn[g].start))
            else $error("Start register moved after first write");

        // The length register takes the first write only
        a_once_length: assert property (@(posedge clk) disable iff (!reset_n)
            st_r.rgn[g].length_wr |=> $stable(st_r.rgn[g].length))
            else $error("Length register moved after first write");

        // The permission register takes the first write only
        a_once_permission_reg: assert property (@(posedge clk) disable iff (!reset_n)
            st_r.rgn[g].permission_reg_wr |=> $stable(st_r.rgn[g].permission_reg))
            else $error("Permission register moved after first write");

        // Enforcement needs all three registers written
        a_all_written: assert property (@(posedge clk) disable iff (!reset_n)
            st_r.rgn[g].enforced |-> (st_r.rgn[g].start_wr && st_r.rgn[g].length_wr && st_r.rgn[g].permission_reg_wr))
            else $error("Region enforced before its triple was written");

        // Enforcement needs a page-aligned start
        a_page_aligned: assert property (@(posedge clk) disable iff (!reset_n)
            st_r.rgn[g].enforced |-> (st_r.rgn[g].start[`FRAG_PAGE_BITS-1:0] == '0))
            else $error("Misaligned region enforced");

        // Enforcement needs nonzero length and permission
        a_nonzero_fields: assert property (@(posedge clk) disable iff (!reset_n)
            st_r.rgn[g].enforced |-> (st_r.rgn[g].length != '0 && st_r.rgn[g].permission_reg != '0))
            else $error("Empty region enforced");

        // Arming takes exactly the two-cycle countdown
        a_arm_count: assert property (@(posedge clk) disable iff (!reset_n)
            (triple_ok(st_r.rgn[g]) && !st_r.rgn[g].enforced && st_r.rgn[g].arm_cnt == '0)
            |=> (!st_r.rgn[g].enforced ##1 st_r.rgn[g].enforced))
            else $error("Region armed off the two-cycle count");

        // Once enforced, a region stays enforced until reset
        a_flag_kept: assert property (@(posedge clk) disable iff (!reset_n)
            st_r.rgn[g].enforced |=> st_r.rgn[g].enforced)
            else $error("Region enforcement dropped without reset");

        // Any covering region that forbids writes refuses the write
        a_union_wr: assert property (@(posedge clk) disable iff (!reset_n)
            (acc.valid && acc.write && covers(st_r.rgn[g], acc.addr) && st_r.rgn[g].permission_reg[`FRAG_PERMISSION_REG_NO_WRITE-1])
            |=> (acc_denied && !flash_acc.valid))
            else $error("Covering region did not refuse the write");

        // Processor reads of a read-protected region are refused as well
        a_cpu_read: assert property (@(posedge clk) disable iff (!reset_n)
            (acc.valid && !acc.write && !acc.debug && covers(st_r.rgn[g], acc.addr)
            && st_r.rgn[g].permission_reg[`FRAG_PERMISSION_REG_NO_READ-1]) |=> (acc_denied && !flash_acc.valid && st_r.rd_zero))
            else $error("Forbidden processor read not refused");

        // Debugger reads of a read-protected region answer zero
        a_dbg_read: assert property (@(posedge clk) disable iff (!reset_n)
            (acc.valid && !acc.write && acc.debug && covers(st_r.rgn[g], acc.addr)
            && st_r.rgn[g].permission_reg[`FRAG_PERMISSION_REG_NO_READ-1]) |=> ##1 (acc_rdata == '0))
            else $error("Forbidden debugger read returned data");

        // Debugger writes to a write-protected region are dropped
        a_dbg_write: assert property (@(posedge clk) disable iff (!reset_n)
            (acc.valid && acc.write && acc.debug && covers(st_r.rgn[g], acc.addr)
            && st_r.rgn[g].permission_reg[`FRAG_PERMISSION_REG_NO_WRITE-1]) |=> (acc_denied && !flash_acc.valid))
            else $error("Forbidden debugger write not dropped");

        // Processor writes to a write-protected region are dropped
        a_cpu_drop: assert property (@(posedge clk) disable iff (!reset_n)
            (acc.valid && acc.write && !acc.debug && covers(st_r.rgn[g], acc.addr)
            && st_r.rgn[g].permission_reg[`FRAG_PERMISSION_REG_NO_WRITE-1]) |=> (acc_denied && !flash_acc.valid))
            else $error("Forbidden processor write reached flash");
    end

endmodule : frag_guard

/* verif/frag_flash_model.sv */
/*
 * Flash array model behind the guard: one word per 4 KB page.
 * Assumes read data are answered in the cycle that flash_acc is valid.
 */
`timescale 1ns/10ps

// ****************************************************************
// Flash array model
// ****************************************************************
module frag_flash_model (
    input wire logic clk,
    input wire frag_pkg::frag_acc_s flash_acc,
    output logic [31:0] flash_rdata
);
    logic [31:0] mem [16];
    logic [31:0] last_r = 32'h0;

    // Known contents so that a dropped write shows up on read-back
    initial for (int i = 0; i < 16; i++) mem[i] = {28'ha5a5a50, 4'(i)};

    // Stores forwarded writes and remembers the last answer
    always @(posedge clk) begin
        if (flash_acc.valid && flash_acc.write) mem[flash_acc.addr[15:12]] <= flash_acc.wdata;
        last_r <= flash_rdata;
    end

    // Outside a read the lines show the inverse, so stale data cannot pass as valid
    always_comb flash_rdata = (flash_acc.valid && !flash_acc.write) ? mem[flash_acc.addr[15:12]] : ~last_r;
endmodule : frag_flash_model

/* verif/testbench.sv */
/*
 * Self-checking bench of the flash region access guard.
 * Assumes frag_pkg and frag_guard are compiled before it.
 */
`timescale 1ns/10ps

// ****************************************************************
// Bench top
// ****************************************************************
module testbench;
    logic clk;
    logic reset_n;
    frag_pkg::frag_reg_req_s req;
    frag_pkg::frag_acc_s acc;
    frag_pkg::frag_acc_s flash_acc;
    logic [31:0] reg_rdata;
    logic [31:0] flash_rdata;
    logic [31:0] acc_rdata;
    logic acc_denied;
    int n_fail;
    int checks_done;

    frag_guard frag_guard_i (.clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(reg_rdata), .acc(acc),
        .flash_acc(flash_acc), .flash_rdata(flash_rdata), .acc_rdata(acc_rdata), .acc_denied(acc_denied));
    frag_flash_model frag_flash_model_i (.clk(clk), .flash_acc(flash_acc), .flash_rdata(flash_rdata));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask : reg_rd

    // A refused access is neither forwarded nor silent: it must pulse denied
    task automatic access(input logic wr, input logic dbg, input logic [19:0] a, input logic [31:0] d,
                          input logic fwd, input logic [31:0] exp);
        @(posedge clk);
        acc <= '{valid: 1'b1, write: wr, debug: dbg, addr: a, wdata: d};
        @(posedge clk);
        acc.valid <= 1'b0;
        #1 chk("forwarded", {31'h0, flash_acc.valid}, {31'h0, fwd});
        chk("denied", {31'h0, acc_denied}, {31'h0, !fwd});
        @(posedge clk);
        #1 if (!wr) chk("read data", acc_rdata, exp);
    endtask : access

    task automatic t_open();
        access(1'b1, 1'b1, 20'h03000, 32'h12345678, 1'b1, 32'h0);
        access(1'b0, 1'b1, 20'h03000, 32'h0, 1'b1, 32'h12345678);
    endtask : t_open

    // Region 0 covers page 1, reads and writes forbidden
    task automatic t_config();
        reg_wr(8'h00, 32'h01000);
        reg_wr(8'h04, 32'h01000);
        reg_wr(8'h08, 32'h3);
        reg_rd(8'h0c, 32'h7, "status early");
        reg_rd(8'h0c, 32'hf, "status armed");
        access(1'b0, 1'b1, 20'h01ffc, 32'h0, 1'b0, 32'h0);
        access(1'b1, 1'b1, 20'h01000, 32'h0, 1'b0, 32'h0);
        access(1'b0, 1'b0, 20'h01000, 32'h0, 1'b0, 32'h0);
    endtask : t_config

    task automatic t_write_once();
        reg_wr(8'h00, 32'h0);
        reg_wr(8'h04, 32'h0);
        reg_wr(8'h08, 32'h0);
        reg_rd(8'h00, 32'h01000, "start");
        reg_rd(8'h04, 32'h01000, "length");
        reg_rd(8'h08, 32'h3, "permission_reg");
        access(1'b0, 1'b1, 20'h01000, 32'h0, 1'b0, 32'h0);
    endtask : t_write_once

    // Region 1 overlaps region 0 and only forbids writes
    task automatic t_overlap();
        reg_wr(8'h10, 32'h01000);
        reg_wr(8'h14, 32'h02000);
        reg_wr(8'h18, 32'h1);
        repeat (3) @(posedge clk);
        access(1'b1, 1'b1, 20'h02000, 32'hdeadbeef, 1'b0, 32'h0);
        access(1'b0, 1'b1, 20'h02000, 32'h0, 1'b1, 32'ha5a5a502);
        access(1'b1, 1'b0, 20'h01000, 32'h0, 1'b0, 32'h0);
        access(1'b0, 1'b1, 20'h01004, 32'h0, 1'b0, 32'h0);
    endtask : t_overlap

    // Misaligned start and unwritten length leave the pages open
    task automatic t_invalid();
        reg_wr(8'h20, 32'h05004);
        reg_wr(8'h24, 32'h01000);
        reg_wr(8'h28, 32'h3);
        reg_wr(8'h30, 32'h06000);
        reg_wr(8'h38, 32'h3);
        repeat (3) @(posedge clk);
        reg_rd(8'h2c, 32'h7, "status misaligned");
        access(1'b0, 1'b1, 20'h05004, 32'h0, 1'b1, 32'ha5a5a505);
        access(1'b0, 1'b1, 20'h06000, 32'h0, 1'b1, 32'ha5a5a506);
    endtask : t_invalid

    task automatic t_mid_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reg_rd(8'h00, 32'h0, "start");
        reg_rd(8'h0c, 32'h0, "status");
        reg_rd(8'h40, 32'h0, "unmapped");
        access(1'b0, 1'b1, 20'h01000, 32'h0, 1'b1, 32'ha5a5a501);
    endtask : t_mid_reset

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        n_fail = 0;
        checks_done = 0;
        req = '0;
        acc = '0;
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_open();
        t_config();
        t_write_once();
        t_overlap();
        t_invalid();
        t_mid_reset();
        stop_test();
    end

    // Watchdog: the whole run needs far fewer than 5000 cycles
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule : testbench
